// [hw/gpsc_top.sv]
// gpio set/clear registers for three ports behind an ahb-lite slave
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module gpsc_top (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // port 0: pins 4..0
  input  wire logic [4:0]  p0_pin_i,
  output logic      [4:0]  p0_pin_o,
  output logic      [4:0]  p0_pin_oe_o,
  // port 1: pins 1..0
  input  wire logic [1:0]  p1_pin_i,
  output logic      [1:0]  p1_pin_o,
  output logic      [1:0]  p1_pin_oe_o,
  // port 2: pins 6,5,1,0 packed as [3:0]
  input  wire logic [3:0]  p2_pin_i,
  output logic      [3:0]  p2_pin_o,
  output logic      [3:0]  p2_pin_oe_o
);

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // address phase capture
  logic                 addr_take;
  gpsc_pkg::gpsc_reg_t  addr_reg;
  logic                 wr_pend_q;
  logic                 wr_pend_d;
  gpsc_pkg::gpsc_reg_t  wr_reg_q;
  gpsc_pkg::gpsc_reg_t  wr_reg_d;

  // only nonseq/seq transfers count; idle and busy are ignored
  assign addr_take = hsel & hready & htrans[1];
  assign addr_reg  = gpsc_pkg::gpsc_decode(haddr);

  assign wr_pend_d = addr_take & hwrite;
  assign wr_reg_d  = wr_pend_d ? addr_reg : gpsc_pkg::REG_NONE;

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_pend_q <= 1'b0;
      wr_reg_q  <= gpsc_pkg::REG_NONE;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_reg_q  <= wr_reg_d;
    end
  end

  // data phase write strobes; hwdata is valid in this cycle
  logic wr_p0_data;
  logic wr_p0_set;
  logic wr_p0_clr;
  logic wr_p1_data;
  logic wr_p1_set;
  logic wr_p1_clr;
  logic wr_p2_data;
  logic wr_p2_set;
  logic wr_p2_clr;

  // each set/clear word is its own write-only location
  assign wr_p0_data = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P0_DATA);
  assign wr_p0_set  = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P0_SET);
  assign wr_p0_clr  = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P0_CLR);
  assign wr_p1_data = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P1_DATA);
  assign wr_p1_set  = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P1_SET);
  assign wr_p1_clr  = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P1_CLR);
  assign wr_p2_data = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P2_DATA);
  assign wr_p2_set  = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P2_SET);
  assign wr_p2_clr  = wr_pend_q & (wr_reg_q == gpsc_pkg::REG_P2_CLR);

  // pin fields: port pins spread to their bit positions in a field
  logic [7:0] p0_in_f;
  logic [7:0] p1_in_f;
  logic [7:0] p2_in_f;
  logic [7:0] p0_out_f;
  logic [7:0] p1_out_f;
  logic [7:0] p2_out_f;
  logic [7:0] p0_dir_f;
  logic [7:0] p1_dir_f;
  logic [7:0] p2_dir_f;
  logic [31:0] p0_word;
  logic [31:0] p1_word;
  logic [31:0] p2_word;

  assign p0_in_f = {3'h0, p0_pin_i};
  assign p1_in_f = {6'h00, p1_pin_i};
  // port 2 uses field bits 6,5,1,0; field bits 7 and 4..2 have no pin here
  assign p2_in_f = {1'h0, p2_pin_i[3:2], 3'h0, p2_pin_i[1:0]};

  gpsc_port_latch #(
    .PIN_MASK (gpsc_pkg::MASK_P0)
  ) u_port0 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_q),
    .wdata_i   (hwdata),
    .data_we_i (wr_p0_data),
    .set_we_i  (wr_p0_set),
    .clr_we_i  (wr_p0_clr),
    .pins_i    (p0_in_f),
    .out_o     (p0_out_f),
    .dir_o     (p0_dir_f),
    .word_o    (p0_word)
  );

  gpsc_port_latch #(
    .PIN_MASK (gpsc_pkg::MASK_P1)
  ) u_port1 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_q),
    .wdata_i   (hwdata),
    .data_we_i (wr_p1_data),
    .set_we_i  (wr_p1_set),
    .clr_we_i  (wr_p1_clr),
    .pins_i    (p1_in_f),
    .out_o     (p1_out_f),
    .dir_o     (p1_dir_f),
    .word_o    (p1_word)
  );

  gpsc_port_latch #(
    .PIN_MASK (gpsc_pkg::MASK_P2)
  ) u_port2 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_q),
    .wdata_i   (hwdata),
    .data_we_i (wr_p2_data),
    .set_we_i  (wr_p2_set),
    .clr_we_i  (wr_p2_clr),
    .pins_i    (p2_in_f),
    .out_o     (p2_out_f),
    .dir_o     (p2_dir_f),
    .word_o    (p2_word)
  );

  // pin drive: latch value shows on the pin while its direction is out
  assign p0_pin_o    = p0_out_f[4:0];
  assign p0_pin_oe_o = p0_dir_f[4:0];
  assign p1_pin_o    = p1_out_f[1:0];
  assign p1_pin_oe_o = p1_dir_f[1:0];
  assign p2_pin_o    = {p2_out_f[6:5], p2_out_f[1:0]};
  assign p2_pin_oe_o = {p2_dir_f[6:5], p2_dir_f[1:0]};

  // read path: data sampled at the address phase edge
  logic [31:0] rdata_sel;
  logic [31:0] rdata_q;
  logic        rd_take;

  assign rd_take = addr_take & ~hwrite;

  // set/clear words read as zero: they hold no state of their own
  always_comb begin
    unique case (addr_reg)
      gpsc_pkg::REG_P0_DATA: rdata_sel = p0_word;
      gpsc_pkg::REG_P1_DATA: rdata_sel = p1_word;
      gpsc_pkg::REG_P2_DATA: rdata_sel = p2_word;
      gpsc_pkg::REG_NONE,
      gpsc_pkg::REG_P0_SET,
      gpsc_pkg::REG_P0_CLR,
      gpsc_pkg::REG_P1_SET,
      gpsc_pkg::REG_P1_CLR,
      gpsc_pkg::REG_P2_SET,
      gpsc_pkg::REG_P2_CLR:  rdata_sel = gpsc_pkg::RDATA_ZERO;
      default:               rdata_sel = gpsc_pkg::RDATA_ZERO;
    endcase
  end

  // a read right behind a write to the same port sees the old latch;
  // the single-transfer master never issues that overlap
  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= gpsc_pkg::RDATA_ZERO;
    end else if (rd_take) begin
      rdata_q <= rdata_sel;
    end
  end

  // zero wait states, always okay
  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = gpsc_pkg::HRESP_OKAY;

endmodule : gpsc_top

// [hw/gpsc_pkg.sv]
// constants, register map and field layout of the gpio set/clear block
// Overview of operation
// - one in port-0 set bits 20..16 drives port-0 pins 4..0 high
// - one in port-1 set bits 17..16 drives port-1 pins 1..0 high
// - one in port-2 set bits 22,21,17,16 drives pins 6,5,1,0 high
// - one in port-0 clear bits 20..16 drives port-0 pins 4..0 low
// - one in port-1 clear bits 17..16 drives port-1 pins 1..0 low
// - one in port-2 clear bits 22,21,17,16 drives pins 6,5,1,0 low
// - zero bits in set or clear words leave their pins unchanged
// - each set or clear word is 32-bit write-only, touching addressed pins
// - port-2 data word bits 22,21,17,16 hold outputs, shown on output pins
package gpsc_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FIELD_W = 8;

  // byte addresses of the memory-mapped words
  localparam logic [31:0] ADDR_P0_DATA = 32'hffff0d20;
  localparam logic [31:0] ADDR_P0_SET  = 32'hffff0d24;
  localparam logic [31:0] ADDR_P0_CLR  = 32'hffff0d28;
  localparam logic [31:0] ADDR_P1_DATA = 32'hffff0d30;
  localparam logic [31:0] ADDR_P1_SET  = 32'hffff0d34;
  localparam logic [31:0] ADDR_P1_CLR  = 32'hffff0d38;
  localparam logic [31:0] ADDR_P2_DATA = 32'hffff0d40;
  localparam logic [31:0] ADDR_P2_SET  = 32'hffff0d44;
  localparam logic [31:0] ADDR_P2_CLR  = 32'hffff0d48;

  // field positions inside a data, set or clear word
  localparam int unsigned LSB_IN  = 0;
  localparam int unsigned LSB_OUT = 16;
  localparam int unsigned LSB_DIR = 24;

  // implemented pin positions per port, within an 8-bit field
  localparam logic [7:0] MASK_P0 = 8'h1f;
  localparam logic [7:0] MASK_P1 = 8'h03;
  localparam logic [7:0] MASK_P2 = 8'h63;

  // reset values: all pins inputs, output latches low
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;

  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // ahb-lite codes
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [3:0] {
    REG_NONE    = 4'h0,
    REG_P0_DATA = 4'h1,
    REG_P0_SET  = 4'h2,
    REG_P0_CLR  = 4'h3,
    REG_P1_DATA = 4'h4,
    REG_P1_SET  = 4'h5,
    REG_P1_CLR  = 4'h6,
    REG_P2_DATA = 4'h7,
    REG_P2_SET  = 4'h8,
    REG_P2_CLR  = 4'h9
  } gpsc_reg_t;

  // pick one 8-bit field out of a word
  function automatic logic [7:0] gpsc_field(input logic [31:0] word, input int unsigned lsb);
    gpsc_field = word[lsb +: FIELD_W];
  endfunction : gpsc_field

  // address decode, shared by read and write paths
  function automatic gpsc_reg_t gpsc_decode(input logic [31:0] addr);
    unique case (addr)
      ADDR_P0_DATA: gpsc_decode = REG_P0_DATA;
      ADDR_P0_SET:  gpsc_decode = REG_P0_SET;
      ADDR_P0_CLR:  gpsc_decode = REG_P0_CLR;
      ADDR_P1_DATA: gpsc_decode = REG_P1_DATA;
      ADDR_P1_SET:  gpsc_decode = REG_P1_SET;
      ADDR_P1_CLR:  gpsc_decode = REG_P1_CLR;
      ADDR_P2_DATA: gpsc_decode = REG_P2_DATA;
      ADDR_P2_SET:  gpsc_decode = REG_P2_SET;
      ADDR_P2_CLR:  gpsc_decode = REG_P2_CLR;
      default:      gpsc_decode = REG_NONE;
    endcase
  endfunction : gpsc_decode

endpackage : gpsc_pkg

// [hw/gpsc_port_latch.sv]
// per-port output latch and direction register with data/set/clear writes
`timescale 1ns/1ns
module gpsc_port_latch #(
  parameter logic [7:0] PIN_MASK = 8'hff
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        data_we_i,
  input  wire logic        set_we_i,
  input  wire logic        clr_we_i,
  input  wire logic [7:0]  pins_i,
  output logic      [7:0]  out_o,
  output logic      [7:0]  dir_o,
  output logic      [31:0] word_o
);

  logic [7:0] out_q;
  logic [7:0] out_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] wr_out;
  logic [7:0] wr_dir;

  // unimplemented positions are masked so they can never latch a one
  assign wr_out = gpsc_pkg::gpsc_field(wdata_i, gpsc_pkg::LSB_OUT) & PIN_MASK;
  assign wr_dir = gpsc_pkg::gpsc_field(wdata_i, gpsc_pkg::LSB_DIR) & PIN_MASK;

  // one bus write per cycle, so the three strobes never coincide
  always_comb begin
    out_d = out_q;
    if (data_we_i) begin
      out_d = wr_out;
    end else if (set_we_i) begin
      out_d = out_q | wr_out;
    end else if (clr_we_i) begin
      out_d = out_q & ~wr_out;
    end
  end

  assign dir_d = data_we_i ? wr_dir : dir_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_q <= gpsc_pkg::RST_OUT;
      dir_q <= gpsc_pkg::RST_DIR;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
    end
  end

  assign out_o = out_q;
  assign dir_o = dir_q;

  // readback of the data word: direction, output latch, pin levels
  always_comb begin
    word_o = gpsc_pkg::RDATA_ZERO;
    word_o[gpsc_pkg::LSB_DIR +: gpsc_pkg::FIELD_W] = dir_q;
    word_o[gpsc_pkg::LSB_OUT +: gpsc_pkg::FIELD_W] = out_q;
    word_o[gpsc_pkg::LSB_IN  +: gpsc_pkg::FIELD_W] = pins_i & PIN_MASK;
  end

endmodule : gpsc_port_latch

// [tb/gpsc_monitor.sv]
// assertions on the gpio set/clear block ports
`timescale 1ns/1ns
module gpsc_monitor (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic [4:0]  p0_pin_o,
  input wire logic [1:0]  p1_pin_o,
  input wire logic [3:0]  p2_pin_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic        wr_q;
  logic        rd_q;
  logic [31:0] a_q;
  // zero wait states: data phase is always the cycle after the address edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q  <= 32'h0;
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      rd_q <= hsel & hready & htrans[1] & ~hwrite;
      a_q  <= haddr;
    end
  end
  wire [4:0] v0 = hwdata[20:16];
  wire [1:0] v1 = hwdata[17:16];
  wire [3:0] v2 = {hwdata[22:21], hwdata[17:16]};
  wire       s0 = wr_q && a_q == 32'hffff0d24;
  wire       c0 = wr_q && a_q == 32'hffff0d28;
  wire       s1 = wr_q && a_q == 32'hffff0d34;
  wire       c1 = wr_q && a_q == 32'hffff0d38;
  wire       s2 = wr_q && a_q == 32'hffff0d44;
  wire       c2 = wr_q && a_q == 32'hffff0d48;
  // non-data words of the block all read zero
  wire       wo = rd_q && a_q[31:8] == 24'hffff0d && a_q[3:0] != 4'h0;
  p0_set_a: assert property (s0 |=> p0_pin_o == ($past(p0_pin_o) | $past(v0)))
    else $error("port0 set wrong");
  p1_set_a: assert property (s1 |=> p1_pin_o == ($past(p1_pin_o) | $past(v1)))
    else $error("port1 set wrong");
  p2_set_a: assert property (s2 |=> p2_pin_o == ($past(p2_pin_o) | $past(v2)))
    else $error("port2 set wrong");
  p0_clr_a: assert property (c0 |=> p0_pin_o == ($past(p0_pin_o) & ~$past(v0)))
    else $error("port0 clear wrong");
  p1_clr_a: assert property (c1 |=> p1_pin_o == ($past(p1_pin_o) & ~$past(v1)))
    else $error("port1 clear wrong");
  p2_clr_a: assert property (c2 |=> p2_pin_o == ($past(p2_pin_o) & ~$past(v2)))
    else $error("port2 clear wrong");
  pin_hold_a: assert property (!wr_q |=> $stable({p0_pin_o, p1_pin_o, p2_pin_o}))
    else $error("pins moved without a write");
  wo_read_a: assert property (wo |-> hrdata == 32'h0)
    else $error("write-only word read nonzero");
endmodule : gpsc_monitor

// [tb/gpsc_pin_model.sv]
// far-side pins: enabled pins echo the latch, released pins show its inverse
`timescale 1ns/1ns
module gpsc_pin_model #(
  parameter int W = 5
) (
  input  wire logic [W-1:0] lvl_i,
  input  wire logic [W-1:0] en_i,
  output logic      [W-1:0] pin_o
);
  // no pulls here, so a released pin must never repeat the stale level
  assign pin_o = lvl_i ~^ en_i;
endmodule : gpsc_pin_model

// [tb/gpsc_top_tb.sv]
// self-checking bench for the gpio set/clear block
`timescale 1ns/1ns
module gpsc_top_tb;
  logic        clk_sys_i  = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         hready     = hreadyout;
  wire  [4:0]  p0_pin_i, p0_pin_o, p0_pin_oe_o;
  wire  [1:0]  p1_pin_i, p1_pin_o, p1_pin_oe_o;
  wire  [3:0]  p2_pin_i, p2_pin_o, p2_pin_oe_o;
  int          n_fail     = 0;
  int          n_compared = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  gpsc_top uut (
    .clk_sys_i, .reset_n_i, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .p0_pin_i, .p0_pin_o, .p0_pin_oe_o,
    .p1_pin_i, .p1_pin_o, .p1_pin_oe_o, .p2_pin_i, .p2_pin_o, .p2_pin_oe_o
  );
  gpsc_pin_model #(.W(5)) pins0 (.lvl_i(p0_pin_o), .en_i(p0_pin_oe_o), .pin_o(p0_pin_i));
  gpsc_pin_model #(.W(2)) pins1 (.lvl_i(p1_pin_o), .en_i(p1_pin_oe_o), .pin_o(p1_pin_i));
  gpsc_pin_model #(.W(4)) pins2 (.lvl_i(p2_pin_o), .en_i(p2_pin_oe_o), .pin_o(p2_pin_i));
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // the master never assumes a latency, but a dead slave must not hang the run
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      if (hready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      $display("[ERR] %0t bus hang", $time);
      final_report();
    end
  endtask : wait_rdy
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= gpsc_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= gpsc_pkg::HTRANS_IDLE;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  // pins update on the data-phase edge, so look half a cycle later
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    @(negedge clk_sys_i);
  endtask : wr
  task automatic s_port0;
    wr(32'hffff0d24, 32'h00150000);
    check(32'(p0_pin_o), 32'h15);
    wr(32'hffff0d24, 32'h000a0000);
    check(32'(p0_pin_o), 32'h1f);
    wr(32'hffff0d28, 32'h00110000);
    check(32'(p0_pin_o), 32'h0e);
    bus(32'hffff0d20, 1'b0, 32'h0);
    check(rd, 32'h000e0011);
    check(32'(p0_pin_oe_o), 32'h0);
  endtask : s_port0
  task automatic s_port1;
    wr(32'hffff0d34, 32'h00020000);
    check(32'(p1_pin_o), 32'h2);
    wr(32'hffff0d34, 32'h00010000);
    check(32'(p1_pin_o), 32'h3);
    wr(32'hffff0d38, 32'h00020000);
    check(32'(p1_pin_o), 32'h1);
    bus(32'hffff0d30, 1'b0, 32'h0);
    check(rd, 32'h00010002);
  endtask : s_port1
  task automatic s_port2;
    wr(32'hffff0d40, 32'h63000000);
    check(32'(p2_pin_oe_o), 32'hf);
    wr(32'hffff0d44, 32'h00600000);
    check(32'(p2_pin_o), 32'hc);
    wr(32'hffff0d44, 32'h00030000);
    check(32'(p2_pin_o), 32'hf);
    wr(32'hffff0d48, 32'h00410000);
    check(32'(p2_pin_o), 32'h6);
    bus(32'hffff0d40, 1'b0, 32'h0);
    check(rd, 32'h63220022);
    bus(32'hffff0d44, 1'b0, 32'h0);
    check(rd, 32'h0);
    bus(32'hffff0d4c, 1'b0, 32'h0);
    check(rd, 32'h0);
  endtask : s_port2
  // mid-run reset must drop every latch and direction bit at once
  task automatic s_reset;
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    @(negedge clk_sys_i);
    check(32'({p0_pin_o, p1_pin_o, p2_pin_o}), 32'h0);
    check(32'({p0_pin_oe_o, p1_pin_oe_o, p2_pin_oe_o}), 32'h0);
    check(hrdata, 32'h0);
    check(32'({hreadyout, hresp}), 32'h2);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    wr(32'hffff0d34, 32'h00010000);
    check(32'(p1_pin_o), 32'h1);
  endtask : s_reset
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    s_port0();
    s_port1();
    s_port2();
    s_reset();
    final_report();
  end
endmodule : gpsc_top_tb
bind gpsc_top gpsc_monitor mon (
  .clk_sys_i, .reset_n_i, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
  .p0_pin_o, .p1_pin_o, .p2_pin_o
);
